// file: rtl/counter_array_control.sv
// counter array run/overflow/module flag control, software timer compare,
// and the first interrupt enable register, on an ahb-lite slave
// assumes: one slave on the bus, hreadyout always high, okay response
// Operation
// - overflow flag bit 7 set whenever the shared counter rolls over
// - overflow flag requests interrupt only while overflow irq enable set
// - hardware never clears overflow or module flags; software writes zero
// - counter stops while run bit 6 is zero, counts while one
// - module n flag in bit n set on match or capture
// - module flag requests interrupt only with its flag irq enable
// - bit 5 reserved, reads undefined; other bits reset to zero
// - comparator and match enable make module a 16-bit software timer
// - timer match interrupts only when flag and flag irq enable set
// - global enable zero blocks all; one lets each enable govern; block_irq here ignores global enable
// - bit 5 gates timer 2 overflow interrupt
// - bit 4 gates serial port interrupt
// - bit 3 gates timer 1 overflow, bit 1 timer 0 overflow
// - bit 2 gates external interrupt 1
// - bit 0 gates external interrupt 0
// - interrupt enable resets to zero; bits individually settable and clearable
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
module counter_array_control
  import counter_array_pkg::*;
#(
  parameter int unsigned modules = num_modules,
  parameter int unsigned cwidth = counter_width
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [addr_width-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [data_width-1:0] hwdata,
  input wire logic hready,
  output logic [data_width-1:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic count_tick,
  input wire logic [modules-1:0] capture_event,
  input wire logic timer2_overflow_req,
  input wire logic serial_port_req,
  input wire logic timer1_overflow_req,
  input wire logic external_irq1_req,
  input wire logic timer0_overflow_req,
  input wire logic external_irq0_req,
  output logic counter_array_irq,
  output logic timer2_overflow_irq,
  output logic serial_port_irq,
  output logic timer1_overflow_irq,
  output logic external_irq1_irq,
  output logic timer0_overflow_irq,
  output logic external_irq0_irq,
  output logic block_irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] interrupt_enable_first;
  logic counter_overflow_flag;
  logic counter_run_bit;
  logic [modules-1:0] module_event_flag;
  logic [7:0] counter_array_mode_reg;
  logic [7:0] module_mode_reg [modules];
  logic [cwidth-1:0] module_compare [modules];
  logic [cwidth-1:0] counter;
  logic [irq_bits-1:0] irq_enable;
  logic [irq_bits-1:0] irq_status;
  logic [irq_bits-1:0] irq_clear;

  logic wr_pending;
  logic [addr_width-1:0] wr_addr;
  logic rd_take;
  logic wr_now;
  logic [data_width-1:0] wdata;
  logic advance;
  logic rollover;
  logic [modules-1:0] match_hit;
  logic [modules-1:0] timer_mode;
  logic [modules-1:0] flag_set;
  logic [modules-1:0] sw_clear;
  logic sw_clear_overflow;
  logic [modules-1:0] flag_irq_en;
  logic [modules-1:0] cap_pulse;
  logic [7:0] next_ien;

  function automatic logic hit(input logic [addr_width-1:0] a, input logic [11:0] target);
    return a == target;
  endfunction

  // ----------------------------------------------------------------
  // ahb-lite slave: zero-wait, writes land in the data phase
  // ----------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign rd_take = hsel && hready && (htrans == htrans_nonseq) && !hwrite;
  assign wr_now = wr_pending;
  assign wdata = hwdata;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pending <= 1'b0;
      wr_addr <= '0;
    end else if (hready) begin
      wr_pending <= hsel && (htrans == htrans_nonseq) && hwrite;
      wr_addr <= haddr;
    end
  end

  // read data registered at the address phase so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (rd_take) begin
      hrdata <= '0;
      if (hit(haddr, addr_interrupt_enable_first)) begin
        hrdata[7:0] <= interrupt_enable_first;
      end else if (hit(haddr, addr_counter_array_control)) begin
        // reserved bit 5 is undefined; it reads zero here
        hrdata[7:0] <= {counter_overflow_flag, counter_run_bit, 1'b0, module_event_flag};
      end else if (hit(haddr, addr_counter_array_mode_reg)) begin
        hrdata[7:0] <= counter_array_mode_reg;
      end else if (hit(haddr, addr_counter_value)) begin
        hrdata[cwidth-1:0] <= counter;
      end else if (hit(haddr, addr_irq_status)) begin
        hrdata[irq_bits-1:0] <= irq_status;
      end else if (hit(haddr, addr_irq_enable)) begin
        hrdata[irq_bits-1:0] <= irq_enable;
      end else begin
        for (int i = 0; i < modules; i++) begin
          if (hit(haddr, 12'(addr_module_mode_base + 12'(i) * addr_word_step))) begin
            hrdata[7:0] <= module_mode_reg[i];
          end
          if (hit(haddr, 12'(addr_module_compare_base + 12'(i) * addr_word_step))) begin
            hrdata[cwidth-1:0] <= module_compare[i];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // first interrupt enable register, with bit set/clear strobes
  // ----------------------------------------------------------------
  always_comb begin
    next_ien = interrupt_enable_first;
    if (wr_now && hit(wr_addr, addr_interrupt_enable_first)) begin
      next_ien = wdata[7:0];
    end else if (wr_now && hit(wr_addr, addr_bit_set)) begin
      next_ien = interrupt_enable_first | wdata[7:0];
    end else if (wr_now && hit(wr_addr, addr_bit_clear)) begin
      next_ien = interrupt_enable_first & ~wdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      interrupt_enable_first <= reset_byte;
    end else begin
      interrupt_enable_first <= next_ien;
    end
  end

  // ----------------------------------------------------------------
  // mode and compare registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      counter_array_mode_reg <= reset_byte;
      irq_enable <= '0;
      for (int i = 0; i < modules; i++) begin
        module_mode_reg[i] <= reset_byte;
        module_compare[i] <= '0;
      end
    end else if (wr_now) begin
      if (hit(wr_addr, addr_counter_array_mode_reg)) begin
        counter_array_mode_reg <= wdata[7:0];
      end
      if (hit(wr_addr, addr_irq_enable)) begin
        irq_enable <= wdata[irq_bits-1:0];
      end
      for (int i = 0; i < modules; i++) begin
        if (hit(wr_addr, 12'(addr_module_mode_base + 12'(i) * addr_word_step))) begin
          module_mode_reg[i] <= wdata[7:0];
        end
        if (hit(wr_addr, 12'(addr_module_compare_base + 12'(i) * addr_word_step))) begin
          module_compare[i] <= wdata[cwidth-1:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // shared counter
  // ----------------------------------------------------------------
  assign advance = counter_run_bit && count_tick;
  assign rollover = advance && (counter == {cwidth{1'b1}});

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      counter <= '0;
    end else if (advance) begin
      counter <= counter + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // control register: run bit and event flags
  // ----------------------------------------------------------------
  assign cap_pulse = (wr_now && hit(wr_addr, addr_module_capture_pulse)) ? wdata[modules-1:0] : '0;

  generate
    for (genvar n = 0; n < modules; n++) begin : g_module
      assign timer_mode[n] = module_mode_reg[n][mmode_comparator_bit] && module_mode_reg[n][mmode_match_bit];
      // compare only on the cycle the counter moves, so a stopped counter
      // does not flag the same value over and over
      assign match_hit[n] = timer_mode[n] && advance && (counter + 1'b1 == module_compare[n]);
      assign flag_set[n] = match_hit[n] || capture_event[n] || cap_pulse[n];
      assign flag_irq_en[n] = module_mode_reg[n][mmode_flag_irq_bit];

      match_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
        match_hit[n] |=> module_event_flag[n] && counter == module_compare[n])
        else $error("match did not flag its module");
    end
  endgenerate

  // only a written zero clears a flag; writing one leaves it alone
  assign sw_clear = (wr_now && hit(wr_addr, addr_counter_array_control)) ? ~wdata[modules-1:0] : '0;
  assign sw_clear_overflow = wr_now && hit(wr_addr, addr_counter_array_control) && !wdata[ctl_overflow_bit];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      counter_run_bit <= 1'b0;
    end else if (wr_now && hit(wr_addr, addr_counter_array_control)) begin
      counter_run_bit <= wdata[ctl_run_bit];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      counter_overflow_flag <= 1'b0;
    end else if (rollover) begin
      counter_overflow_flag <= 1'b1;
    end else if (sw_clear_overflow) begin
      counter_overflow_flag <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      module_event_flag <= '0;
    end else begin
      module_event_flag <= (module_event_flag & ~sw_clear) | flag_set;
    end
  end

  // ----------------------------------------------------------------
  // interrupt gating
  // ----------------------------------------------------------------
  logic ca_request;
  logic global_irq_enable;
  assign global_irq_enable = interrupt_enable_first[ien_global_bit];
  assign ca_request = (counter_overflow_flag && counter_array_mode_reg[mode_overflow_irq_bit])
    || |(module_event_flag & flag_irq_en);
  assign counter_array_irq = global_irq_enable && interrupt_enable_first[ien_counter_array_bit]
    && ca_request;
  assign timer2_overflow_irq = global_irq_enable && interrupt_enable_first[ien_timer2_bit]
    && timer2_overflow_req;
  assign serial_port_irq = global_irq_enable && interrupt_enable_first[ien_serial_bit] && serial_port_req;
  assign timer1_overflow_irq = global_irq_enable && interrupt_enable_first[ien_timer1_bit]
    && timer1_overflow_req;
  assign timer0_overflow_irq = global_irq_enable && interrupt_enable_first[ien_timer0_bit]
    && timer0_overflow_req;
  assign external_irq1_irq = global_irq_enable && interrupt_enable_first[ien_ext1_bit]
    && external_irq1_req;
  assign external_irq0_irq = global_irq_enable && interrupt_enable_first[ien_ext0_bit]
    && external_irq0_req;

  // ----------------------------------------------------------------
  // block event status, enable and write-one clear
  // ----------------------------------------------------------------
  assign irq_clear = (wr_now && hit(wr_addr, addr_irq_clear)) ? wdata[irq_bits-1:0] : '0;

  sticky_event_bits #(
    .width(irq_bits)
  ) u_status (
    .hclk(hclk),
    .hresetn(hresetn),
    .set_pulse({flag_set, rollover}),
    .clear_pulse(irq_clear),
    .flags(irq_status)
  );

  assign block_irq = |(irq_status & irq_enable);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  rollover_sets_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rollover |=> counter_overflow_flag)
    else $error("rollover did not set overflow flag");

  overflow_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (counter_overflow_flag && !counter_array_mode_reg[mode_overflow_irq_bit] && module_event_flag == '0)
    |-> !counter_array_irq)
    else $error("overflow irq without enable");

  flag_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (counter_overflow_flag && !sw_clear_overflow) |=> counter_overflow_flag)
    else $error("overflow flag cleared by hardware");

  counter_stop_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !counter_run_bit |=> $stable(counter))
    else $error("counter moved while stopped");

  global_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !interrupt_enable_first[ien_global_bit] |-> !(counter_array_irq || timer2_overflow_irq || serial_port_irq
      || timer1_overflow_irq || timer0_overflow_irq || external_irq1_irq || external_irq0_irq))
    else $error("interrupt passed with global enable low");

  module_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (!counter_overflow_flag && (module_event_flag & flag_irq_en) == '0) |-> !counter_array_irq)
    else $error("module flag irq without enable");

  ca_request_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (global_irq_enable && interrupt_enable_first[ien_counter_array_bit] && (module_event_flag & flag_irq_en) != '0)
    |-> counter_array_irq)
    else $error("enabled module flag gave no irq");

  serial_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    serial_port_irq |-> interrupt_enable_first[ien_serial_bit] && serial_port_req)
    else $error("serial irq without enable");

  ien_reset_a: assert property (@(posedge hclk)
    $rose(hresetn) |-> interrupt_enable_first == reset_byte)
    else $error("enable register not zero after reset");

endmodule

// file: rtl/counter_array_pkg.sv
// package: register map, field positions and reset values of the counter array
// control block and the first interrupt enable register
// assumes: 32-bit ahb-lite register bus, one word per register
package counter_array_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int unsigned num_modules = 5;
  localparam int unsigned counter_width = 16;
  localparam int unsigned addr_width = 12;
  localparam int unsigned data_width = 32;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] addr_interrupt_enable_first = 12'h0A8;
  localparam logic [11:0] addr_counter_array_control = 12'h0D8;
  localparam logic [11:0] addr_counter_array_mode_reg = 12'h100;
  localparam logic [11:0] addr_module_mode_base = 12'h104;
  localparam logic [11:0] addr_module_compare_base = 12'h120;
  localparam logic [11:0] addr_counter_value = 12'h140;
  localparam logic [11:0] addr_module_capture_pulse = 12'h144;
  localparam logic [11:0] addr_irq_status = 12'h150;
  localparam logic [11:0] addr_irq_enable = 12'h154;
  localparam logic [11:0] addr_irq_clear = 12'h158;
  localparam logic [11:0] addr_bit_set = 12'h160;
  localparam logic [11:0] addr_bit_clear = 12'h164;
  localparam logic [11:0] addr_word_step = 12'h004;

  // ----------------------------------------------------------------
  // fields
  // ----------------------------------------------------------------
  localparam int unsigned ctl_overflow_bit = 7;
  localparam int unsigned ctl_run_bit = 6;
  localparam int unsigned ctl_reserved_bit = 5;
  localparam int unsigned ien_global_bit = 7;
  localparam int unsigned ien_counter_array_bit = 6;
  localparam int unsigned ien_timer2_bit = 5;
  localparam int unsigned ien_serial_bit = 4;
  localparam int unsigned ien_timer1_bit = 3;
  localparam int unsigned ien_ext1_bit = 2;
  localparam int unsigned ien_timer0_bit = 1;
  localparam int unsigned ien_ext0_bit = 0;
  localparam int unsigned mode_overflow_irq_bit = 0;
  localparam int unsigned mmode_comparator_bit = 6;
  localparam int unsigned mmode_match_bit = 3;
  localparam int unsigned mmode_flag_irq_bit = 0;
  // irq status layout: bit 0 overflow event, bits 1..5 module events
  localparam int unsigned irq_bits = 6;

  localparam logic [7:0] reset_byte = 8'h00;
  localparam logic [1:0] htrans_nonseq = 2'h2;
  localparam logic [2:0] hsize_word = 3'h2;

endpackage

// file: rtl/sticky_event_bits.sv
// sticky flag bank: hardware sets, software clears, set wins a tie
// assumes: set and clear are one-cycle pulses in the hclk domain
`timescale 1ns/1ns
module sticky_event_bits #(
  parameter int unsigned width = 6
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [width-1:0] set_pulse,
  input wire logic [width-1:0] clear_pulse,
  output logic [width-1:0] flags
);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags <= '0;
    end else begin
      flags <= (flags & ~clear_pulse) | set_pulse;
    end
  end

  sticky_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    |set_pulse |=> ((flags & $past(set_pulse)) == $past(set_pulse)))
    else $error("sticky set lost");

endmodule

// file: tb/tb.sv
// testbench for the counter array control block and the first interrupt enable register
// assumes: one zero-wait ahb-lite slave, a single 100 ns clock, async active-low reset
`timescale 1ns/1ns
module tb;
  import counter_array_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic hclk, hresetn, hsel, hwrite, count_tick;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata;
  logic hreadyout, hresp, counter_array_irq, block_irq;
  logic [4:0] capture_event;
  logic [5:0] reqv, src_irq;
  int bad_count, samples_checked;

  counter_array_control uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .count_tick(count_tick), .capture_event(capture_event),
    .timer2_overflow_req(reqv[5]), .serial_port_req(reqv[4]), .timer1_overflow_req(reqv[3]),
    .external_irq1_req(reqv[2]), .timer0_overflow_req(reqv[1]), .external_irq0_req(reqv[0]),
    .counter_array_irq(counter_array_irq), .timer2_overflow_irq(src_irq[5]),
    .serial_port_irq(src_irq[4]), .timer1_overflow_irq(src_irq[3]), .external_irq1_irq(src_irq[2]),
    .timer0_overflow_irq(src_irq[1]), .external_irq0_irq(src_irq[0]), .block_irq(block_irq));

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // waits at most 50 edges for hready, so a stuck slave ends the run
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      bad_count++;
      test_done();
    end
  endtask

  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    hsize <= hsize_word;
    htrans <= htrans_nonseq;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    r = hrdata;
    // return mid-cycle so callers see what the data-phase edge launched
    @(negedge hclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(a, 1'b1, d, r);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(a, 1'b0, 32'h0, r);
    chk(r, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask

  // check levels mid-cycle, after the write edge has landed
  task automatic pin_chk(input logic [31:0] got_sel, input logic [31:0] exp);
    @(negedge hclk);
    chk(got_sel, exp);
  endtask

  task automatic tick(input int n);
    @(posedge hclk);
    count_tick <= 1'b1;
    repeat (n) @(posedge hclk);
    count_tick <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values();
    rd_chk(addr_interrupt_enable_first, 32'h0);
    rd_chk(addr_counter_array_control, 32'h0);
    rd_chk(addr_counter_value, 32'h0);
    wr(12'h0F0, 32'hFF);
    rd_chk(12'h0F0, 32'h0);
  endtask

  task automatic t_enable_gating();
    @(posedge hclk);
    reqv <= 6'h3F;
    for (int i = 0; i < 6; i++) begin
      wr(addr_interrupt_enable_first, 32'(1 << i));
      pin_chk({26'h0, src_irq}, 32'h0);
      wr(addr_interrupt_enable_first, 32'h80 | 32'(1 << i));
      pin_chk({26'h0, src_irq}, 32'(1 << i));
    end
    wr(addr_interrupt_enable_first, 32'h0);
    wr(addr_bit_set, 32'h81);
    rd_chk(addr_interrupt_enable_first, 32'h81);
    wr(addr_bit_clear, 32'h01);
    rd_chk(addr_interrupt_enable_first, 32'h80);
    pin_chk({26'h0, src_irq}, 32'h0);
  endtask

  task automatic t_counter_run();
    tick(4);
    rd_chk(addr_counter_value, 32'h0);
    wr(addr_counter_array_control, 32'h40);
    tick(4);
    rd_chk(addr_counter_value, 32'h4);
  endtask

  // module 2 as software timer, compare at 7, counter now at 4
  task automatic t_match_flags();
    wr(addr_module_mode_base + 12'h008, 32'h49);
    wr(addr_module_compare_base + 12'h008, 32'h7);
    tick(2);
    rd_chk(addr_counter_array_control, 32'h40);
    tick(1);
    rd_chk(addr_counter_array_control, 32'h44);
    wr(addr_interrupt_enable_first, 32'h40);
    pin_chk({31'h0, counter_array_irq}, 32'h0);
    wr(addr_interrupt_enable_first, 32'h80);
    pin_chk({31'h0, counter_array_irq}, 32'h0);
    wr(addr_interrupt_enable_first, 32'hC0);
    pin_chk({31'h0, counter_array_irq}, 32'h1);
    wr(addr_module_mode_base + 12'h008, 32'h48);
    pin_chk({31'h0, counter_array_irq}, 32'h0);
    wr(addr_module_mode_base + 12'h008, 32'h49);
    tick(3);
    rd_chk(addr_counter_array_control, 32'h44);
    wr(addr_counter_array_control, 32'hDB);
    rd_chk(addr_counter_array_control, 32'h40);
    pin_chk({31'h0, counter_array_irq}, 32'h0);
  endtask

  // status bit 3 is module 2; it stays set after the flag was cleared
  task automatic t_status_irq();
    pin_chk({31'h0, block_irq}, 32'h0);
    rd_chk(addr_irq_status, 32'h08);
    wr(addr_irq_enable, 32'h08);
    pin_chk({31'h0, block_irq}, 32'h1);
    wr(addr_irq_clear, 32'h08);
    pin_chk({31'h0, block_irq}, 32'h0);
    rd_chk(addr_irq_status, 32'h0);
  endtask

  // counter at 10: 65526 ticks make it roll over to zero
  // module 2 timer off first, or passing its compare value sets its flag again
  task automatic t_overflow();
    wr(addr_module_mode_base + 12'h008, 32'h00);
    wr(addr_counter_array_mode_reg, 32'h01);
    tick(65526);
    rd_chk(addr_counter_value, 32'h0);
    rd_chk(addr_counter_array_control, 32'hC0);
    rd_chk(addr_irq_status, 32'h01);
    pin_chk({31'h0, counter_array_irq}, 32'h1);
    wr(addr_counter_array_mode_reg, 32'h00);
    pin_chk({31'h0, counter_array_irq}, 32'h0);
    wr(addr_counter_array_control, 32'h5F);
    rd_chk(addr_counter_array_control, 32'h40);
  endtask

  task automatic t_capture();
    @(posedge hclk);
    capture_event <= 5'h10;
    @(posedge hclk);
    capture_event <= 5'h00;
    wr(addr_module_capture_pulse, 32'h01);
    rd_chk(addr_counter_array_control, 32'h51);
    rd_chk(addr_irq_status, 32'h23);
    wr(addr_counter_array_control, 32'h00);
    rd_chk(addr_counter_array_control, 32'h00);
    tick(5);
    rd_chk(addr_counter_value, 32'h0);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    bad_count = 0;
    samples_checked = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = hsize_word;
    hwdata = 32'h0;
    count_tick = 1'b0;
    capture_event = 5'h00;
    reqv = 6'h00;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset_values();
    t_enable_gating();
    t_counter_run();
    t_match_flags();
    t_status_irq();
    t_overflow();
    t_capture();
    test_done();
  end
endmodule
